// ---- logic/srstc_top.v ----
// System reset controller: source merge, start-up stretch, cause flags
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "srstc_defs.vh"
module srstc_top #(
  parameter DLY_W = 16  // Start-up counter width
) (
  input  wire        hclk,            // System clock, 125 MHz
  input  wire        hresetn,         // Bus reset, async, active low
  input  wire        por_active,      // Power-on detector, high = low Vcc
  input  wire        ext_reset_n,     // External reset pin, active low
  input  wire        wdt_expire,      // Watchdog time-out, one-cycle pulse
  input  wire        bod_below,       // Brown-out comparator, high = low
  input  wire        debug_reset_reg, // Debug-port reset scan register
  input  wire [2:0]  brownout_level_fuse, // Brown-out level code
  input  wire [1:0]  startup_time_fuse,   // Start-up time select
  input  wire [3:0]  clock_select_fuse,   // Clock source select
  input  wire        hsel,            // AHB select
  input  wire [11:0] haddr,           // AHB address
  input  wire [1:0]  htrans,          // AHB transfer type
  input  wire        hwrite,          // AHB write
  input  wire [2:0]  hsize,           // AHB size
  input  wire        hready,          // AHB ready in
  input  wire [31:0] hwdata,          // AHB write data
  output reg  [31:0] hrdata,          // AHB read data
  output wire        hreadyout,       // AHB ready out
  output wire        hresp,           // AHB response, always OKAY
  output wire        port_reset_n,    // Async force of port pins
  output reg         sys_reset_n,     // Stretched internal reset
  output wire        fetch_vector,    // Fetch from reset vector pulse
  output wire        brownout_enable, // Brown-out detector enable
  output wire        fuse_reserved    // Reserved brown-out code seen
);
  // ----------------------------------------------------------------
  // Source combination
  // ----------------------------------------------------------------
  reg         wdt_pulse;
  reg         wdt_en;
  wire        bod_en;
  wire        ext_lvl;
  wire        ext_q;
  wire        async_src;
  wire        any_src;
  reg  [DLY_W-1:0] dly_cnt;
  reg  [DLY_W-1:0] dly_limit;
  reg         any_q;

  // Codes 111, 110 and 101 keep the detector off
  assign bod_en = (brownout_level_fuse != `SRSTC_BOD_OFF) &&
                  (brownout_level_fuse != `SRSTC_BOD_RSV6) &&
                  (brownout_level_fuse != `SRSTC_BOD_RSV5);
  assign brownout_enable = bod_en;
  assign fuse_reserved = (brownout_level_fuse == `SRSTC_BOD_RSV6) ||
                         (brownout_level_fuse == `SRSTC_BOD_RSV5);

  // Clockless sources act on the pins with no flip-flop in the way
  assign async_src = por_active | ~ext_reset_n |
                     (bod_en & bod_below) | debug_reset_reg;
  assign port_reset_n = ~(async_src | wdt_pulse);

  // Clocked view of the pin, for the cause flag
  srstc_sync #(.RST_VAL(1'b0)) u_ext_sync (
    .hclk   (hclk),
    .arst_n (hresetn),
    .d      (~ext_reset_n),
    .q      (ext_q)
  );
  assign ext_lvl = ext_q;

  // Watchdog request is gated by the enable, one cycle wide
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_pulse <= 1'b0;
    else
      wdt_pulse <= wdt_expire & wdt_en;
  end

  assign any_src = async_src | wdt_pulse;

  // ----------------------------------------------------------------
  // Start-up delay
  // ----------------------------------------------------------------
  // Delay set from fuses; a plain add and shift keeps it one cycle to decode
  always @*
  begin
    dly_limit = {{(DLY_W-6){1'b0}}, clock_select_fuse, startup_time_fuse}
                + {{(DLY_W-1){1'b0}}, 1'b1};
    dly_limit = dly_limit << 4;
  end

  // Async assert keeps reset immediate; release waits out the count.
  // Counter clears whenever a source is live so a re-assert restarts it.
  always @(posedge hclk or posedge any_src)
  begin
    if (any_src)
    begin
      sys_reset_n <= 1'b0;
      dly_cnt     <= {DLY_W{1'b0}};
    end
    else if (!sys_reset_n)
    begin
      // Counting begins after the last source falls, incl. watchdog
      if (dly_cnt >= dly_limit - {{(DLY_W-1){1'b0}}, 1'b1})
        sys_reset_n <= 1'b1;
      else
        dly_cnt <= dly_cnt + {{(DLY_W-1){1'b0}}, 1'b1};
    end
  end

  // Release edge tells the core to fetch from the reset vector
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      any_q <= 1'b0;
    else
      any_q <= sys_reset_n;
  end
  assign fetch_vector = sys_reset_n & ~any_q;

  // ----------------------------------------------------------------
  // Reset-cause register
  // ----------------------------------------------------------------
  localparam [7:0] CAUSE_INIT = `SRSTC_CAUSE_RST; // Full-width reset value
  reg  [4:0] cause;
  reg        wr_pend;
  reg  [11:0] wr_addr;
  wire       ahb_go;
  wire       wr_cause;
  wire       wr_ctrl;
  wire [4:0] set_v;

  assign ahb_go = hsel & hready & htrans[1];
  assign wr_cause = wr_pend && (wr_addr == `SRSTC_CAUSE_ADDR);
  assign wr_ctrl  = wr_pend && (wr_addr == `SRSTC_CTRL_ADDR);

  // Events that set flags; set wins over a same-cycle write of zero
  assign set_v[`SRSTC_POR_BIT] = por_active;
  assign set_v[`SRSTC_EXT_BIT] = ext_lvl;
  assign set_v[`SRSTC_BOR_BIT] = bod_en & bod_below;
  assign set_v[`SRSTC_WDT_BIT] = wdt_pulse;
  assign set_v[`SRSTC_DBG_BIT] = debug_reset_reg;

  // Power-on clears every flag but its own; bus reset leaves them
  // standing so software can read them after the release.
  always @(posedge hclk)
  begin
    if (por_active)
      cause <= CAUSE_INIT[4:0];
    else if (wr_cause)
      cause <= (cause & hwdata[4:0]) | set_v;
    else
      cause <= cause | set_v;
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; writes land in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      wdt_en  <= 1'b0;
      hrdata  <= 32'h00000000;
    end
    else
    begin
      wr_pend <= ahb_go & hwrite;
      if (ahb_go)
        wr_addr <= haddr;
      if (wr_ctrl)
        wdt_en <= hwdata[`SRSTC_CTRL_WDEN_BIT];
      if (ahb_go && !hwrite)
      begin
        if (haddr == `SRSTC_CAUSE_ADDR)
          hrdata <= {27'h0, cause};
        else if (haddr == `SRSTC_CTRL_ADDR)
          hrdata <= {31'h0, wdt_en};
        else if (haddr == `SRSTC_STATE_ADDR)
          hrdata <= {29'h0, fuse_reserved, bod_en, sys_reset_n};
        else
          hrdata <= 32'h00000000;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

// ---- common/srstc_defs.vh ----
// Constants for the system reset controller
`ifndef SRSTC_DEFS_VH
`define SRSTC_DEFS_VH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SRSTC_CAUSE_ADDR   12'h000
`define SRSTC_CTRL_ADDR    12'h004
`define SRSTC_STATE_ADDR   12'h008
// ----------------------------------------------------------------
// Reset-cause field positions
// ----------------------------------------------------------------
`define SRSTC_POR_BIT      0
`define SRSTC_EXT_BIT      1
`define SRSTC_BOR_BIT      2
`define SRSTC_WDT_BIT      3
`define SRSTC_DBG_BIT      4
`define SRSTC_CAUSE_RST    8'h01
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SRSTC_CTRL_WDEN_BIT 0
`define SRSTC_CTRL_RST     8'h00
// ----------------------------------------------------------------
// Brown-out level fuse codes
// ----------------------------------------------------------------
`define SRSTC_BOD_OFF      3'h7
`define SRSTC_BOD_RSV6     3'h6
`define SRSTC_BOD_RSV5     3'h5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRSTC_CLK_NS       8
`define SRSTC_TRST_NS      400
// Least time rounds up to whole cycles
`define SRSTC_TRST_CYC     ((`SRSTC_TRST_NS + `SRSTC_CLK_NS - 1) / `SRSTC_CLK_NS)
`define SRSTC_DLY_UNIT     1024
`endif

// ---- logic/srstc_sync.v ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module srstc_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire hclk,    // System clock
  input  wire arst_n,  // Asynchronous reset
  input  wire d,       // Raw input from another domain
  output reg  q        // Filtered level
);
  reg s1;
  reg s2;
  reg s3;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always @(posedge hclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
  end
endmodule

// ---- verification/srstc_assertions.sv ----
// Port-level checks for the system reset controller
`timescale 1ns/10ps
module srstc_assertions (
  input wire       hclk,                // System clock
  input wire       hresetn,             // Bus reset
  input wire       por_active,          // Power-on source
  input wire       ext_reset_n,         // Pin source
  input wire       bod_below,           // Brown-out source
  input wire       debug_reset_reg,     // Debug source
  input wire [2:0] brownout_level_fuse, // Level code
  input wire       port_reset_n,        // Pin force
  input wire       sys_reset_n,         // Internal reset
  input wire       fetch_vector,        // Vector fetch
  input wire       brownout_enable,     // Detector on
  input wire       fuse_reserved        // Reserved code
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Sources force pins and core at once; the stretch holds afterwards
  por_force_a:
    assert property (por_active |-> !port_reset_n && !sys_reset_n)
    else $error("power-on not forcing reset");
  dbg_hold_a:
    assert property (debug_reset_reg |-> !sys_reset_n)
    else $error("debug register not holding reset");
  bod_force_a:
    assert property (brownout_enable && bod_below |-> !port_reset_n)
    else $error("brown-out not forcing pins");
  bod_off_a:
    assert property (brownout_level_fuse >= 3'h5 |-> !brownout_enable)
    else $error("detector on for off code");
  bod_on_a:
    assert property (brownout_level_fuse < 3'h5 |-> brownout_enable)
    else $error("detector off for level code");
  rsv_code_a:
    assert property (brownout_level_fuse inside {3'h5, 3'h6} |->
      fuse_reserved) else $error("reserved code not flagged");
  por_hold_a:
    assert property ($fell(por_active) |-> !sys_reset_n [*8])
    else $error("power-on release too early");
  ext_hold_a:
    assert property ($rose(ext_reset_n) && !$past(ext_reset_n, 4) |->
      !sys_reset_n [*8]) else $error("pin release too early");
  or_merge_a:
    assert property (!port_reset_n |-> !sys_reset_n)
    else $error("pin force without core reset");
  fetch_one_a:
    assert property ($rose(sys_reset_n) |-> ##[0:1] fetch_vector
      ##1 !fetch_vector) else $error("vector fetch pulse wrong");
endmodule
bind srstc_top srstc_assertions srstc_assertions_inst (.hclk, .hresetn,
  .por_active, .ext_reset_n, .bod_below, .debug_reset_reg,
  .brownout_level_fuse, .port_reset_n, .sys_reset_n, .fetch_vector,
  .brownout_enable, .fuse_reserved);

// ---- verification/srstc_sources.sv ----
// Supply monitors, reset pin and debug port seen by the controller
`timescale 1ns/10ps
module srstc_sources (
  input  wire hclk,            // System clock
  output reg  por_active,      // Supply below power-on level
  output reg  ext_reset_n,     // Pin, pulled up when released
  output reg  wdt_expire,      // Watchdog time-out
  output reg  bod_below,       // Supply below brown-out level
  output reg  debug_reset_reg  // Debug-port reset register
);
  // Supply starts low, so power-on is active from time zero
  initial
  begin
    {por_active, ext_reset_n} = 2'h3;
    {wdt_expire, bod_below, debug_reset_reg} = 3'h0;
  end
  // One source for len cycles; watchdog pulse is always one cycle
  task fire(input integer src, input integer len);
    @(posedge hclk);
    case (src)
      0: por_active <= 1'b1;
      1: ext_reset_n <= 1'b0;
      2: bod_below <= 1'b1;
      3: wdt_expire <= 1'b1;
      default: debug_reset_reg <= 1'b1;
    endcase
    repeat ((src == 3) ? 1 : len) @(posedge hclk);
    {por_active, wdt_expire, bod_below, debug_reset_reg} <= 4'h0;
    ext_reset_n <= 1'b1;
  endtask
endmodule

// ---- verification/system_reset_controller_test.sv ----
// Self-checking bench for the system reset controller
`timescale 1ns/10ps
module system_reset_controller_test;
  reg         hclk, hresetn, hsel, hwrite;
  reg  [1:0]  htrans, sut_fuse;
  reg  [2:0]  hsize, bl_fuse;
  reg  [3:0]  cks_fuse;
  reg  [11:0] haddr;
  reg  [31:0] hwdata, rd, wd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, port_reset_n, sys_reset_n, fetch_vector;
  wire        brownout_enable, fuse_reserved, por_active, ext_reset_n;
  wire        wdt_expire, bod_below, debug_reset_reg;
  integer     n_mismatch = 0, samples_checked = 0, seed = 51145;
  integer     exp_cause, d, i, k;
  srstc_top srstc_top_inst (.hclk, .hresetn, .por_active, .ext_reset_n,
    .wdt_expire, .bod_below, .debug_reset_reg, .brownout_level_fuse(bl_fuse),
    .startup_time_fuse(sut_fuse), .clock_select_fuse(cks_fuse), .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .port_reset_n, .sys_reset_n, .fetch_vector,
    .brownout_enable, .fuse_reserved);
  srstc_sources srstc_sources_inst (.hclk, .por_active, .ext_reset_n,
    .wdt_expire, .bod_below, .debug_reset_reg);
  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single word transfer; hold each phase until ready is seen
  task bus(input w, input [11:0] a, input [31:0] wdat, output [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wdat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Count cycles until release; the registered watchdog pulse may add one
  task rel(input integer lo);
    // One edge first: a watchdog pulse lands only after the fire edge
    @(posedge hclk);
    k = 1;
    while (sys_reset_n !== 1'b1 && k < 3000)
    begin
      @(posedge hclk);
      k = k + 1;
    end
    chk("stretch", 1, k >= lo && k <= lo + 6);
  endtask
  task close_out;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  // Bring-up, every source, restart, fuse codes, unmapped space
  initial
  begin
    {hresetn, hwrite, htrans, haddr, hwdata} = 0;
    {hsel, hsize, bl_fuse, sut_fuse, cks_fuse} = {1'b1, 3'h2, 3'h7, 6'h0};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    srstc_sources_inst.fire(0, 10);
    rel(16);
    exp_cause = 1;
    bus(0, 12'h000, 0, rd);
    chk("cause", exp_cause, rd);
    wd = $random(seed);
    bus(1, 12'h000, wd, rd);
    exp_cause = exp_cause & wd[4:0];
    srstc_sources_inst.fire(3, 1);
    repeat (4) @(posedge hclk);
    chk("wdt_off", 1, sys_reset_n);
    srstc_sources_inst.fire(2, 60);
    chk("bod_off", 1, sys_reset_n);
    bus(1, 12'h004, 1, rd);
    bus(0, 12'h004, 0, rd);
    chk("ctrl", 1, rd);
    for (i = 1; i < 5; i = i + 1)
    begin
      cks_fuse <= $random(seed) & 1;
      sut_fuse <= $random(seed);
      bl_fuse <= {$random(seed)} % 5;
      @(posedge hclk);
      d = (cks_fuse * 4 + sut_fuse + 1) * 16;
      srstc_sources_inst.fire(i, 60);
      rel(d);
      exp_cause = exp_cause | (1 << i);
      bus(0, 12'h000, 0, rd);
      chk("cause", exp_cause, rd);
    end
    srstc_sources_inst.fire(4, 3);
    repeat (8) @(posedge hclk);
    srstc_sources_inst.fire(4, 3);
    rel(d);
    srstc_sources_inst.fire(0, 5);
    rel(d);
    bus(0, 12'h000, 0, rd);
    chk("cause", 1, rd);
    bus(1, 12'h000, 0, rd);
    bus(0, 12'h000, 0, rd);
    chk("cause", 0, rd);
    for (i = 0; i < 8; i = i + 1)
    begin
      bl_fuse <= i;
      bus(0, 12'h008, 0, rd);
      chk("state", {(i == 5 || i == 6), (i < 5), 1'b1}, rd);
    end
    bus(1, 12'h00c, 32'hffffffff, rd);
    bus(0, 12'h00c, 0, rd);
    chk("unmapped", 0, rd);
    chk("hresp", 0, hresp);
    close_out;
  end
endmodule
